/* File: core/dcfs_cfg.svh */
// Constants for the dual-clock queue status flag block
`ifndef DCFS_CFG_SVH
`define DCFS_CFG_SVH

// Queue geometry and pointer arithmetic
`define DCFS_PTR_W 13
`define DCFS_OFS_W 12
`define DCFS_DEPTH 13'h1000
`define DCFS_PTR_ONE 13'h0001
`define DCFS_OFS_PRESET 12'h008
`define DCFS_FALL_THROUGH_MODE_RESET 1'b0

// Serial offset load: 48 bits, high offset of each pair first
`define DCFS_SER_W 48
`define DCFS_SER_CNT_W 6
`define DCFS_SER_BITS 6'h30
`define DCFS_SER_ONE 6'h01
`define DCFS_SER_Y1_LSB 36
`define DCFS_SER_X1_LSB 24
`define DCFS_SER_Y2_LSB 12
`define DCFS_SER_X2_LSB 0

// Pin vector positions
`define DCFS_PIN_W 8
`define DCFS_PIN_A_CLK 0
`define DCFS_PIN_B_CLK 1
`define DCFS_PIN_A_WR 2
`define DCFS_PIN_A_RD 3
`define DCFS_PIN_B_WR 4
`define DCFS_PIN_B_RD 5
`define DCFS_PIN_SER_EN_N 6
`define DCFS_PIN_SER_DATA 7

// Queue indices
`define DCFS_Q_A2B 0
`define DCFS_Q_B2A 1

// Register map (byte addresses)
`define DCFS_ADDR_W 8
`define DCFS_REG_CTRL 8'h00
`define DCFS_REG_A2B_EMPTY_OFS 8'h04
`define DCFS_REG_A2B_FULL_OFS 8'h08
`define DCFS_REG_B2A_EMPTY_OFS 8'h0c
`define DCFS_REG_B2A_FULL_OFS 8'h10
`define DCFS_REG_STATUS 8'h14
`define DCFS_REG_A2B_FILL 8'h18
`define DCFS_REG_B2A_FILL 8'h1c
`define DCFS_CTRL_FALL_THROUGH_MODE_BIT 0

// Status register bit positions
`define DCFS_ST_A_EMPTY 0
`define DCFS_ST_A_AE_N 1
`define DCFS_ST_A_FULL 2
`define DCFS_ST_A_AF_N 3
`define DCFS_ST_B_EMPTY 4
`define DCFS_ST_B_AE_N 5
`define DCFS_ST_B_FULL 6
`define DCFS_ST_B_AF_N 7

`define DCFS_RESP_OKAY 2'b00
`define DCFS_RESP_SLVERR 2'b10

`endif

/* File: core/dcfs_pkg.sv */
// Types for the dual-clock queue status flag block
`include "dcfs_cfg.svh"

package dcfs_pkg;
  typedef logic [`DCFS_PTR_W-1:0] dcfs_ptr_t;
  typedef logic [`DCFS_OFS_W-1:0] dcfs_ofs_t;
  typedef logic [`DCFS_ADDR_W-1:0] dcfs_addr_t;

  typedef struct packed {
    dcfs_ptr_t wr_ptr;
    dcfs_ptr_t rd_ptr;
    dcfs_ptr_t wr_sync1;
    dcfs_ptr_t wr_sync2;
    dcfs_ptr_t rd_sync1;
    dcfs_ptr_t rd_sync2;
    logic out_ready;
  } dcfs_queue_s;

  typedef struct packed {
    logic [`DCFS_PIN_W-1:0] pin_s1;
    logic [`DCFS_PIN_W-1:0] pin_s2;
    logic [1:0] clk_prev;
    dcfs_queue_s [1:0] q;
    logic fall_through_mode;
    dcfs_ofs_t [1:0] ofs_empty;
    dcfs_ofs_t [1:0] ofs_full;
    logic [`DCFS_SER_W-1:0] ser_shift;
    logic [`DCFS_SER_CNT_W-1:0] ser_cnt;
    logic aw_valid;
    dcfs_addr_t aw_addr;
    logic w_valid;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } dcfs_state_s;
endpackage : dcfs_pkg

/* File: core/dcfs_status.sv */
// Status flag logic for two opposite-direction 4096-word queues between two clocked ports
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`include "dcfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dcfs_status (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Port A pins
  input wire logic port_a_clock,
  input wire logic port_a_write_qual,
  input wire logic port_a_read_qual,
  input wire logic serial_load_en_n,
  input wire logic serial_load_data,
  // Port B pins
  input wire logic port_b_clock,
  input wire logic port_b_write_qual,
  input wire logic port_b_read_qual,
  // Port A flags
  output logic port_a_empty_or_out_ready,
  output logic port_a_almost_empty_n,
  output logic port_a_full_or_in_ready,
  output logic port_a_almost_full_n,
  // Port B flags
  output logic port_b_empty_or_out_ready,
  output logic port_b_almost_empty_n,
  output logic port_b_full_or_in_ready,
  output logic port_b_almost_full_n,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire dcfs_pkg::dcfs_addr_t s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire dcfs_pkg::dcfs_addr_t s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import dcfs_pkg::*;

  dcfs_state_s s_q;
  dcfs_state_s s_d;

  logic edge_a;
  logic edge_b;
  logic [1:0] wr_edge;
  logic [1:0] rd_edge;
  logic [1:0] wr_qual;
  logic [1:0] rd_qual;
  logic [`DCFS_PIN_W-1:0] pins;
  logic [7:0] flags;

  // Words in memory as seen by the reader; the output register word is already counted out
  function automatic dcfs_ptr_t mem_fill(input dcfs_queue_s q);
    mem_fill = q.wr_sync2 - q.rd_ptr;
  endfunction : mem_fill

  // Words in memory as seen by the writer
  function automatic dcfs_ptr_t wr_fill(input dcfs_queue_s q);
    wr_fill = q.wr_ptr - q.rd_sync2;
  endfunction : wr_fill

  function automatic logic mem_has_word(input dcfs_queue_s q);
    mem_has_word = (q.wr_sync2 != q.rd_ptr);
  endfunction : mem_has_word

  function automatic logic empty_flag(input dcfs_queue_s q, input logic fall_through_mode);
    empty_flag = fall_through_mode ? q.out_ready : mem_has_word(q);
  endfunction : empty_flag

  function automatic logic in_ready(input dcfs_queue_s q);
    in_ready = (wr_fill(q) != `DCFS_DEPTH);
  endfunction : in_ready

  function automatic logic almost_empty_n(input dcfs_queue_s q, input dcfs_ofs_t x);
    almost_empty_n = (mem_fill(q) > {1'b0, x});
  endfunction : almost_empty_n

  function automatic logic almost_full_n(input dcfs_queue_s q, input dcfs_ofs_t y);
    almost_full_n = (({1'b0, wr_fill(q)} + {2'b00, y}) < {1'b0, `DCFS_DEPTH});
  endfunction : almost_full_n

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    merge_bytes = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        merge_bytes[k*8 +: 8] = data[k*8 +: 8];
      end
    end
  endfunction : merge_bytes

  function automatic logic reg_mapped(input dcfs_addr_t addr);
    case (addr)
      `DCFS_REG_CTRL, `DCFS_REG_A2B_EMPTY_OFS, `DCFS_REG_A2B_FULL_OFS, `DCFS_REG_B2A_EMPTY_OFS,
      `DCFS_REG_B2A_FULL_OFS, `DCFS_REG_STATUS, `DCFS_REG_A2B_FILL, `DCFS_REG_B2A_FILL: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  assign pins = {serial_load_data, serial_load_en_n, port_b_read_qual, port_b_write_qual,
                 port_a_read_qual, port_a_write_qual, port_b_clock, port_a_clock};

  // Port clocks are sampled pins; their rising edges become one-cycle enables
  assign edge_a = s_q.pin_s2[`DCFS_PIN_A_CLK] & ~s_q.clk_prev[0];
  assign edge_b = s_q.pin_s2[`DCFS_PIN_B_CLK] & ~s_q.clk_prev[1];

  // A-to-B queue is written by port A and read by port B; the other one the reverse
  assign wr_edge = {edge_b, edge_a};
  assign rd_edge = {edge_a, edge_b};
  assign wr_qual = {s_q.pin_s2[`DCFS_PIN_B_WR], s_q.pin_s2[`DCFS_PIN_A_WR]};
  assign rd_qual = {s_q.pin_s2[`DCFS_PIN_A_RD], s_q.pin_s2[`DCFS_PIN_B_RD]};

  // Reader flags come from the write pointer as synchronised by reader edges, writer flags the reverse
  assign port_a_empty_or_out_ready = empty_flag(s_q.q[`DCFS_Q_B2A], s_q.fall_through_mode);
  assign port_a_almost_empty_n = almost_empty_n(s_q.q[`DCFS_Q_B2A], s_q.ofs_empty[`DCFS_Q_B2A]);
  assign port_a_full_or_in_ready = in_ready(s_q.q[`DCFS_Q_A2B]);
  assign port_a_almost_full_n = almost_full_n(s_q.q[`DCFS_Q_A2B], s_q.ofs_full[`DCFS_Q_A2B]);
  assign port_b_empty_or_out_ready = empty_flag(s_q.q[`DCFS_Q_A2B], s_q.fall_through_mode);
  assign port_b_almost_empty_n = almost_empty_n(s_q.q[`DCFS_Q_A2B], s_q.ofs_empty[`DCFS_Q_A2B]);
  assign port_b_full_or_in_ready = in_ready(s_q.q[`DCFS_Q_B2A]);
  assign port_b_almost_full_n = almost_full_n(s_q.q[`DCFS_Q_B2A], s_q.ofs_full[`DCFS_Q_B2A]);

  always_comb begin
    flags = 8'h00;
    flags[`DCFS_ST_A_EMPTY] = port_a_empty_or_out_ready;
    flags[`DCFS_ST_A_AE_N] = port_a_almost_empty_n;
    flags[`DCFS_ST_A_FULL] = port_a_full_or_in_ready;
    flags[`DCFS_ST_A_AF_N] = port_a_almost_full_n;
    flags[`DCFS_ST_B_EMPTY] = port_b_empty_or_out_ready;
    flags[`DCFS_ST_B_AE_N] = port_b_almost_empty_n;
    flags[`DCFS_ST_B_FULL] = port_b_full_or_in_ready;
    flags[`DCFS_ST_B_AF_N] = port_b_almost_full_n;
  end

  assign s_axi_awready = ~s_q.aw_valid & ~s_q.b_valid;
  assign s_axi_wready = ~s_q.w_valid & ~s_q.b_valid;
  assign s_axi_bvalid = s_q.b_valid;
  assign s_axi_bresp = s_q.b_resp;
  assign s_axi_arready = ~s_q.r_valid;
  assign s_axi_rvalid = s_q.r_valid;
  assign s_axi_rdata = s_q.r_data;
  assign s_axi_rresp = s_q.r_resp;

  always_comb begin
    logic [`DCFS_SER_W-1:0] ser_next;
    logic [31:0] wval;
    ser_next = {s_q.ser_shift[`DCFS_SER_W-2:0], s_q.pin_s2[`DCFS_PIN_SER_DATA]};
    wval = 32'h0000_0000;
    s_d = s_q;

    // Two-stage pin sampling; the first stage feeds only the second
    s_d.pin_s1 = pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.clk_prev = {s_q.pin_s2[`DCFS_PIN_B_CLK], s_q.pin_s2[`DCFS_PIN_A_CLK]};

    for (int i = 0; i < 2; i++) begin
      // Writer side: the read pointer crosses on two writer edges, so a freed slot shows on the second
      if (wr_edge[i]) begin
        s_d.q[i].rd_sync1 = s_q.q[i].rd_ptr;
        s_d.q[i].rd_sync2 = s_q.q[i].rd_sync1;
        if (wr_qual[i] && in_ready(s_q.q[i])) begin
          s_d.q[i].wr_ptr = s_q.q[i].wr_ptr + `DCFS_PTR_ONE;
        end
      end
      // Reader side: the write pointer crosses on two reader edges
      if (rd_edge[i]) begin
        s_d.q[i].wr_sync1 = s_q.q[i].wr_ptr;
        s_d.q[i].wr_sync2 = s_q.q[i].wr_sync1;
        if (s_q.fall_through_mode) begin
          if (!s_q.q[i].out_ready) begin
            // Autoload uses the already synchronised view, landing on the third reader edge
            if (mem_has_word(s_q.q[i])) begin
              s_d.q[i].out_ready = 1'b1;
              s_d.q[i].rd_ptr = s_q.q[i].rd_ptr + `DCFS_PTR_ONE;
            end
          end else if (rd_qual[i]) begin
            if (mem_has_word(s_q.q[i])) begin
              s_d.q[i].rd_ptr = s_q.q[i].rd_ptr + `DCFS_PTR_ONE;
            end else begin
              s_d.q[i].out_ready = 1'b0;
            end
          end
        end else begin
          s_d.q[i].out_ready = 1'b0;
          if (rd_qual[i] && mem_has_word(s_q.q[i])) begin
            s_d.q[i].rd_ptr = s_q.q[i].rd_ptr + `DCFS_PTR_ONE;
          end
        end
      end
    end

    // Serial offset load shifts on port A edges while enabled, and stops after the last bit
    if (edge_a && !s_q.pin_s2[`DCFS_PIN_SER_EN_N] && (s_q.ser_cnt != `DCFS_SER_BITS)) begin
      s_d.ser_shift = ser_next;
      s_d.ser_cnt = s_q.ser_cnt + `DCFS_SER_ONE;
      if ((s_q.ser_cnt + `DCFS_SER_ONE) == `DCFS_SER_BITS) begin
        s_d.ofs_full[`DCFS_Q_A2B] = ser_next[`DCFS_SER_Y1_LSB +: `DCFS_OFS_W];
        s_d.ofs_empty[`DCFS_Q_A2B] = ser_next[`DCFS_SER_X1_LSB +: `DCFS_OFS_W];
        s_d.ofs_full[`DCFS_Q_B2A] = ser_next[`DCFS_SER_Y2_LSB +: `DCFS_OFS_W];
        s_d.ofs_empty[`DCFS_Q_B2A] = ser_next[`DCFS_SER_X2_LSB +: `DCFS_OFS_W];
      end
    end

    // Write channel: address and data are taken in either order, the write happens once both are held
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_valid = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_valid = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_valid && s_q.w_valid && !s_q.b_valid) begin
      s_d.aw_valid = 1'b0;
      s_d.w_valid = 1'b0;
      s_d.b_valid = 1'b1;
      s_d.b_resp = reg_mapped(s_q.aw_addr) ? `DCFS_RESP_OKAY : `DCFS_RESP_SLVERR;
      case (s_q.aw_addr)
        `DCFS_REG_CTRL: begin
          wval = merge_bytes({31'h0000_0000, s_q.fall_through_mode}, s_q.w_data, s_q.w_strb);
          s_d.fall_through_mode = wval[`DCFS_CTRL_FALL_THROUGH_MODE_BIT];
        end
        `DCFS_REG_A2B_EMPTY_OFS: begin
          wval = merge_bytes({20'h0_0000, s_q.ofs_empty[`DCFS_Q_A2B]}, s_q.w_data, s_q.w_strb);
          s_d.ofs_empty[`DCFS_Q_A2B] = wval[`DCFS_OFS_W-1:0];
        end
        `DCFS_REG_A2B_FULL_OFS: begin
          wval = merge_bytes({20'h0_0000, s_q.ofs_full[`DCFS_Q_A2B]}, s_q.w_data, s_q.w_strb);
          s_d.ofs_full[`DCFS_Q_A2B] = wval[`DCFS_OFS_W-1:0];
        end
        `DCFS_REG_B2A_EMPTY_OFS: begin
          wval = merge_bytes({20'h0_0000, s_q.ofs_empty[`DCFS_Q_B2A]}, s_q.w_data, s_q.w_strb);
          s_d.ofs_empty[`DCFS_Q_B2A] = wval[`DCFS_OFS_W-1:0];
        end
        `DCFS_REG_B2A_FULL_OFS: begin
          wval = merge_bytes({20'h0_0000, s_q.ofs_full[`DCFS_Q_B2A]}, s_q.w_data, s_q.w_strb);
          s_d.ofs_full[`DCFS_Q_B2A] = wval[`DCFS_OFS_W-1:0];
        end
        default: begin
          wval = 32'h0000_0000;
        end
      endcase
    end
    if (s_q.b_valid && s_axi_bready) begin
      s_d.b_valid = 1'b0;
    end

    // Read channel: one cycle to answer, data held until taken
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.r_valid = 1'b1;
      s_d.r_resp = reg_mapped(s_axi_araddr) ? `DCFS_RESP_OKAY : `DCFS_RESP_SLVERR;
      case (s_axi_araddr)
        `DCFS_REG_CTRL: s_d.r_data = {31'h0000_0000, s_q.fall_through_mode};
        `DCFS_REG_A2B_EMPTY_OFS: s_d.r_data = {20'h0_0000, s_q.ofs_empty[`DCFS_Q_A2B]};
        `DCFS_REG_A2B_FULL_OFS: s_d.r_data = {20'h0_0000, s_q.ofs_full[`DCFS_Q_A2B]};
        `DCFS_REG_B2A_EMPTY_OFS: s_d.r_data = {20'h0_0000, s_q.ofs_empty[`DCFS_Q_B2A]};
        `DCFS_REG_B2A_FULL_OFS: s_d.r_data = {20'h0_0000, s_q.ofs_full[`DCFS_Q_B2A]};
        `DCFS_REG_STATUS: s_d.r_data = {24'h00_0000, flags};
        `DCFS_REG_A2B_FILL: s_d.r_data = {19'h0_0000, mem_fill(s_q.q[`DCFS_Q_A2B])};
        `DCFS_REG_B2A_FILL: s_d.r_data = {19'h0_0000, mem_fill(s_q.q[`DCFS_Q_B2A])};
        default: s_d.r_data = 32'h0000_0000;
      endcase
    end else if (s_q.r_valid && s_axi_rready) begin
      s_d.r_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // Cleared pointers leave empty-side flags low and full-side flags high
      s_q <= '0;
      s_q.fall_through_mode <= `DCFS_FALL_THROUGH_MODE_RESET;
      s_q.ofs_empty <= {`DCFS_OFS_PRESET, `DCFS_OFS_PRESET};
      s_q.ofs_full <= {`DCFS_OFS_PRESET, `DCFS_OFS_PRESET};
    end else begin
      s_q <= s_d;
    end
  end
endmodule : dcfs_status

`default_nettype wire

/* File: dv/dcfs_status_properties.sv */
// Port-level timing checker for the dual-clock queue status flag block
`include "dcfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dcfs_status_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Port clock pins
  input wire logic port_a_clock,
  input wire logic port_b_clock,
  // Flags
  input wire logic port_a_empty_or_out_ready,
  input wire logic port_a_almost_empty_n,
  input wire logic port_a_full_or_in_ready,
  input wire logic port_a_almost_full_n,
  input wire logic port_b_empty_or_out_ready,
  input wire logic port_b_almost_empty_n,
  input wire logic port_b_full_or_in_ready,
  input wire logic port_b_almost_full_n,
  // Status read
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire dcfs_pkg::dcfs_addr_t s_axi_araddr,
  input wire logic [31:0] s_axi_rdata
);
  import dcfs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] flags;
  assign flags = {port_b_almost_full_n, port_b_full_or_in_ready, port_b_almost_empty_n, port_b_empty_or_out_ready,
                  port_a_almost_full_n, port_a_full_or_in_ready, port_a_almost_empty_n, port_a_empty_or_out_ready};

  // A flag may only move a few cycles after a rising edge of its own port clock pin
  property p_from_pin(logic flag, logic pin);
    $changed(flag) |-> ($past(pin) || $past(pin, 2) || $past(pin, 3) || $past(pin, 4) || $past(pin, 5));
  endproperty

  chk_reset_flag_levels: assert property ($fell(sys_rst) |-> flags == 8'hcc)
    else $error("flags not at their reset levels after reset");
  chk_a_ready_domain: assert property (p_from_pin(port_a_empty_or_out_ready, port_a_clock))
    else $error("port A read flag moved without a port A edge");
  chk_b_ready_domain: assert property (p_from_pin(port_b_empty_or_out_ready, port_b_clock))
    else $error("port B read flag moved without a port B edge");
  chk_a_full_domain: assert property (p_from_pin(port_a_full_or_in_ready, port_a_clock))
    else $error("port A write flag moved without a port A edge");
  chk_b_ae_domain: assert property (p_from_pin(port_b_almost_empty_n, port_b_clock))
    else $error("port B almost-empty moved without a port B edge");
  chk_a_af_domain: assert property (p_from_pin(port_a_almost_full_n, port_a_clock))
    else $error("port A almost-full moved without a port A edge");
  chk_full_implies_af: assert property (!port_a_full_or_in_ready |-> !port_a_almost_full_n)
    else $error("full queue without almost-full");
  chk_status_mirror: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `DCFS_REG_STATUS
    |=> s_axi_rdata == {24'h000000, $past(flags)})
    else $error("status word differs from the flag pins");

  cover property (!port_a_full_or_in_ready);
  cover property ($rose(port_a_empty_or_out_ready));
  cover property ($rose(port_b_almost_empty_n));
endmodule : dcfs_status_chk

bind dcfs_status dcfs_status_chk chk_u (.*);

`default_nettype wire

/* File: dv/dcfs_port_ctl.sv */
// Port controller model: makes port clock cycles with qualified transfers
`timescale 1ns/1ps
`default_nettype none

module dcfs_port_ctl (
  // Clock
  input wire logic sys_clk,
  // Flags seen by each controller, index 0 is port A
  input wire logic [1:0] can_rd,
  input wire logic [1:0] can_wr,
  // Port pins
  output logic [1:0] pclk,
  output logic [1:0] wr_q,
  output logic [1:0] rd_q
);
  initial begin
    pclk = 2'b00;
    wr_q = 2'b00;
    rd_q = 2'b00;
  end

  // Clock stands low between calls; qualifiers straddle the rise by more than the pin samplers need.
  // Insist lets a scenario try a transfer that the flags forbid.
  task port_edge(input int p, input logic wr, input logic rd, input logic insist);
    @(posedge sys_clk);
    wr_q[p] <= wr & (can_wr[p] | insist);
    rd_q[p] <= rd & (can_rd[p] | insist);
    repeat (3) @(posedge sys_clk);
    pclk[p] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    pclk[p] <= 1'b0;
    wr_q[p] <= 1'b0;
    rd_q[p] <= 1'b0;
  endtask : port_edge
endmodule : dcfs_port_ctl

`default_nettype wire

/* File: dv/dcfs_status_tb.sv */
// Self-checking bench for the dual-clock queue status flag block
`include "dcfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dcfs_status_tb;
  import dcfs_pkg::*;
  logic sys_clk, sys_rst;
  logic [1:0] pclk, wr_q, rd_q;
  logic a_rdy, a_ae_n, a_full, a_af_n, b_rdy, b_ae_n, b_full, b_af_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  dcfs_addr_t awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic ser_en_n, ser_data;
  logic [47:0] pat;
  int fails, n_compared, i;

  dcfs_port_ctl pm_u (.sys_clk(sys_clk), .can_rd({b_rdy, a_rdy}), .can_wr({b_full, a_full}),
    .pclk(pclk), .wr_q(wr_q), .rd_q(rd_q));

  dcfs_status dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .port_a_clock(pclk[0]), .port_a_write_qual(wr_q[0]), .port_a_read_qual(rd_q[0]),
    .serial_load_en_n(ser_en_n), .serial_load_data(ser_data),
    .port_b_clock(pclk[1]), .port_b_write_qual(wr_q[1]), .port_b_read_qual(rd_q[1]),
    .port_a_empty_or_out_ready(a_rdy), .port_a_almost_empty_n(a_ae_n),
    .port_a_full_or_in_ready(a_full), .port_a_almost_full_n(a_af_n),
    .port_b_empty_or_out_ready(b_rdy), .port_b_almost_empty_n(b_ae_n),
    .port_b_full_or_in_ready(b_full), .port_b_almost_full_n(b_af_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task give_verdict;
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Handshakes are judged at the falling edge, where the combinational readies are settled
  task axi_wr(input dcfs_addr_t addr, input logic [31:0] data, input logic [1:0] exp);
    int n;
    logic ta, tw, done;
    @(posedge sys_clk);
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      done = bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    if (!done) begin
      fails++;
      give_verdict();
    end
    cmp("write response", {30'h0, exp}, {30'h0, r});
  endtask : axi_wr

  task axi_rd(input dcfs_addr_t addr);
    int n;
    logic ta, done;
    @(posedge sys_clk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) begin
      fails++;
      give_verdict();
    end
  endtask : axi_rd

  task rd_chk(input dcfs_addr_t addr, input logic [31:0] exp, input string what);
    axi_rd(addr);
    cmp(what, exp, d);
  endtask : rd_chk

  // One port clock cycle, then let the flags settle before they are looked at
  task edge_x(input int p, input logic wr, input logic rd, input logic insist);
    pm_u.port_edge(p, wr, rd, insist);
    @(negedge sys_clk);
  endtask : edge_x

  initial begin
    fails = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    ser_en_n = 1'b1;
    ser_data = 1'b0;
    pat = 48'h123456789abc;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd_chk(`DCFS_REG_STATUS, 32'h000000cc, "reset status");
    rd_chk(`DCFS_REG_A2B_EMPTY_OFS, 32'h00000008, "offset preset");
    axi_rd(8'h20);
    cmp("unmapped resp", {30'h0, `DCFS_RESP_SLVERR}, {30'h0, r});
    cmp("unmapped data", 32'h00000000, d);
    axi_wr(`DCFS_REG_A2B_EMPTY_OFS, 32'h00000002, `DCFS_RESP_OKAY);
    rd_chk(`DCFS_REG_A2B_EMPTY_OFS, 32'h00000002, "offset written");
    // Standard mode, A to B: a read tried while the flag is low must be dropped
    edge_x(0, 1'b1, 1'b0, 1'b0);
    edge_x(1, 1'b0, 1'b1, 1'b1);
    cmp("b ready edge1", 32'h0, b_rdy);
    edge_x(1, 1'b0, 1'b0, 1'b0);
    cmp("b ready edge2", 32'h1, b_rdy);
    rd_chk(`DCFS_REG_A2B_FILL, 32'h00000001, "a2b fill ignored read");
    edge_x(0, 1'b1, 1'b0, 1'b0);
    edge_x(0, 1'b1, 1'b0, 1'b0);
    for (i = 0; i < 2; i++) begin
      edge_x(1, 1'b0, 1'b0, 1'b0);
      cmp("b almost empty", i, b_ae_n);
    end
    edge_x(1, 1'b0, 1'b1, 1'b0);
    edge_x(1, 1'b0, 1'b0, 1'b0);
    cmp("b almost empty at offset", 32'h0, b_ae_n);
    rd_chk(`DCFS_REG_A2B_FILL, 32'h00000002, "a2b fill after read");
    edge_x(1, 1'b0, 1'b1, 1'b0);
    edge_x(1, 1'b0, 1'b1, 1'b0);
    cmp("b ready drained", 32'h0, b_rdy);
    // Fall-through, B to A: the first word loads itself on the third reader edge
    axi_wr(`DCFS_REG_CTRL, 32'h00000001, `DCFS_RESP_OKAY);
    edge_x(1, 1'b1, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) begin
      edge_x(0, 1'b0, 1'b0, 1'b0);
      cmp("a out ready", i == 2, a_rdy);
    end
    rd_chk(`DCFS_REG_B2A_FILL, 32'h00000000, "b2a fill with held word");
    edge_x(1, 1'b1, 1'b0, 1'b0);
    edge_x(0, 1'b0, 1'b0, 1'b0);
    edge_x(0, 1'b0, 1'b0, 1'b0);
    rd_chk(`DCFS_REG_B2A_FILL, 32'h00000001, "b2a fill second word");
    edge_x(0, 1'b0, 1'b1, 1'b0);
    cmp("a out ready reload", 32'h1, a_rdy);
    edge_x(0, 1'b0, 1'b1, 1'b0);
    cmp("a out ready spent", 32'h0, a_rdy);
    edge_x(0, 1'b0, 1'b1, 1'b1);
    cmp("a out ready ignored read", 32'h0, a_rdy);
    rd_chk(`DCFS_REG_B2A_FILL, 32'h00000000, "b2a fill ignored read");
    axi_wr(`DCFS_REG_CTRL, 32'h00000000, `DCFS_RESP_OKAY);
    // Fill A to B completely; extra write is refused, then free space returns two edges after a read
    for (i = 0; i < 4096; i++) edge_x(0, 1'b1, 1'b0, 1'b0);
    cmp("a full", 32'h0, a_full);
    cmp("a almost full", 32'h0, a_af_n);
    edge_x(0, 1'b1, 1'b0, 1'b1);
    edge_x(1, 1'b0, 1'b0, 1'b0);
    edge_x(1, 1'b0, 1'b0, 1'b0);
    rd_chk(`DCFS_REG_A2B_FILL, 32'h00001000, "a2b fill when full");
    edge_x(1, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 2; i++) begin
      edge_x(0, 1'b0, 1'b0, 1'b0);
      cmp("a full release", i, a_full);
    end
    for (i = 0; i < 8; i++) edge_x(1, 1'b0, 1'b1, 1'b0);
    for (i = 0; i < 2; i++) begin
      edge_x(0, 1'b0, 1'b0, 1'b0);
      cmp("a almost full release", i, a_af_n);
    end
    edge_x(0, 1'b1, 1'b0, 1'b0);
    cmp("a almost full boundary", 32'h0, a_af_n);
    rd_chk(`DCFS_REG_STATUS, 32'h000000f4, "status mirror");
    // Serial load: 48 bits on port A edges, A-to-B full offset MSB first
    @(posedge sys_clk);
    ser_en_n <= 1'b0;
    for (i = 0; i < 48; i++) begin
      @(posedge sys_clk);
      ser_data <= pat[47-i];
      edge_x(0, 1'b0, 1'b0, 1'b0);
    end
    @(posedge sys_clk);
    ser_en_n <= 1'b1;
    rd_chk(`DCFS_REG_A2B_FULL_OFS, 32'h00000123, "serial a2b full offset");
    rd_chk(`DCFS_REG_A2B_EMPTY_OFS, 32'h00000456, "serial a2b empty offset");
    rd_chk(`DCFS_REG_B2A_FULL_OFS, 32'h00000789, "serial b2a full offset");
    rd_chk(`DCFS_REG_B2A_EMPTY_OFS, 32'h00000abc, "serial b2a empty offset");
    give_verdict();
  end
endmodule : dcfs_status_tb

`default_nettype wire
